// *** inc/trs_pkg.sv ***
// Package of constants and carrier types for the temperature result block
package trs_pkg;

  // Register read pointers
  localparam logic [7:0] TRS_PTR_REMOTE_HI = 8'h01;
  localparam logic [7:0] TRS_PTR_FLAGS     = 8'h02;
  localparam logic [7:0] TRS_PTR_REMOTE_LO = 8'h10;

  // Reset values
  localparam logic [7:0] TRS_RESULT_RST = 8'h00;
  localparam logic [7:0] TRS_FLAGS_RST  = 8'h00;

  // Status bit positions
  localparam int TRS_BIT_BUSY         = 7;
  localparam int TRS_BIT_LOCAL_OVER   = 6;
  localparam int TRS_BIT_LOCAL_UNDER  = 5;
  localparam int TRS_BIT_REMOTE_OVER  = 4;
  localparam int TRS_BIT_REMOTE_UNDER = 3;
  localparam int TRS_BIT_OPEN         = 2;
  localparam int TRS_BIT_RSHUT        = 1;
  localparam int TRS_BIT_LSHUT        = 0;

  // Flags that hold until a status read, per pin mode
  localparam logic [6:0] TRS_LATCH_ALERT = 7'h7c;
  localparam logic [6:0] TRS_LATCH_PIN2  = 7'h04;

  // Fraction nibble position inside the low byte
  localparam int TRS_FRAC_LSB = 4;

  // Live conditions from the comparators, index = status bit
  typedef struct packed {
    logic [6:0] cond;
  } trs_cond_t;

  // Host read strobe with its pointer
  typedef struct packed {
    logic       rd;
    logic [7:0] ptr;
  } trs_read_t;

  // Pair lock owner
  typedef enum logic [1:0] {
    TRS_LOCK_NONE,
    TRS_LOCK_HI_HELD,
    TRS_LOCK_LO_HELD
  } trs_lock_t;

endpackage

// *** rtl/trs_result_store.sv ***
// Small register store holding the remote result pair
`timescale 1ns/100ps
`default_nettype none
module trs_result_store
  import trs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr_hi,
  input  wire logic        wr_lo,
  input  wire logic [11:0] result,
  output logic      [7:0]  hi_q,
  output logic      [3:0]  lo_q
);

  // Each byte loads independently so the lock can freeze one half
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hi_q <= TRS_RESULT_RST;
      lo_q <= TRS_RESULT_RST[3:0];
    end
    else
    begin
      if (wr_hi)
        hi_q <= result[11:4];
      if (wr_lo)
        lo_q <= result[3:0];
    end
  end

endmodule
`default_nettype wire

// *** rtl/trs_regs.sv ***
// Remote result pair with read lock and latched status flags
`timescale 1ns/100ps
`default_nettype none
module trs_regs
  import trs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        conv_busy,
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_result,
  input  wire trs_cond_t   cond_in,
  input  wire logic        shutdown2_mode,
  input  wire trs_read_t   host_read,
  output logic      [7:0]  read_data,
  output logic             read_valid
);

  // Block state apart from the result pair held in u_store
  typedef struct packed {
    trs_lock_t  lock;
    logic [6:0] flags;
    logic [7:0] data;
    logic       valid;
  } trs_state_t;

  trs_state_t st_reg;
  trs_state_t st_next;
  logic [7:0] hi_q;
  logic [3:0] lo_q;
  logic       wr_hi;
  logic       wr_lo;
  logic [6:0] latch_mask;
  logic [7:0] status_now;

  // Ptr compare used in several places
  function automatic logic hit(input trs_read_t r, input logic [7:0] p);
    hit = r.rd && (r.ptr == p);
  endfunction

  // Result pair storage
  trs_result_store u_store (
    .clk    (clk),
    .rst    (rst),
    .wr_hi  (wr_hi),
    .wr_lo  (wr_lo),
    .result (conv_result),
    .hi_q   (hi_q),
    .lo_q   (lo_q)
  );

  // Loads gated by the lock owner
  assign wr_hi = conv_done && (st_reg.lock != TRS_LOCK_LO_HELD);
  assign wr_lo = conv_done && (st_reg.lock != TRS_LOCK_HI_HELD);

  // Flags that latch; the two shutdown flags never latch and follow
  // their cause; in shutdown2 mode only the open flag latches, so the
  // limit flags then just follow their live condition
  always_comb
  begin
    latch_mask = TRS_LATCH_ALERT;
    if (shutdown2_mode)
      latch_mask = TRS_LATCH_PIN2;
  end

  // Live busy plus latched flags, as seen by a read
  assign status_now = {conv_busy, st_reg.flags};

  always_comb
  begin
    st_next = st_reg;
    st_next.valid = 1'b0;
    // Flag update; set from the live cause always wins over a clear
    for (int i = 0; i < 7; i++)
    begin
      if (cond_in.cond[i])
        st_next.flags[i] = 1'b1;
      else if (hit(host_read, TRS_PTR_FLAGS))
        st_next.flags[i] = 1'b0;
      else if (!latch_mask[i])
        st_next.flags[i] = 1'b0;
    end
    if (host_read.rd)
    begin
      st_next.valid = 1'b1;
      unique case (host_read.ptr)
        TRS_PTR_REMOTE_HI:
        begin
          st_next.data = hi_q;
          if (st_reg.lock == TRS_LOCK_LO_HELD)
            st_next.lock = TRS_LOCK_NONE;
          else
            st_next.lock = TRS_LOCK_HI_HELD;
        end
        TRS_PTR_REMOTE_LO:
        begin
          st_next.data = {lo_q, 4'h0};
          if (st_reg.lock == TRS_LOCK_HI_HELD)
            st_next.lock = TRS_LOCK_NONE;
          else
            st_next.lock = TRS_LOCK_LO_HELD;
        end
        TRS_PTR_FLAGS:
        begin
          st_next.data = status_now;
          st_next.lock = TRS_LOCK_NONE;
        end
        default:
        begin
          // Outside this block's registers; answered with zero and a valid pulse
          st_next.data = 8'h00;
          st_next.lock = TRS_LOCK_NONE;
        end
      endcase
    end
  end

  // Single state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg.lock  <= TRS_LOCK_NONE;
      st_reg.flags <= TRS_FLAGS_RST[6:0];
      st_reg.data  <= 8'h00;
      st_reg.valid <= 1'b0;
    end
    else
      st_reg <= st_next;
  end

  assign read_data  = st_reg.data;
  assign read_valid = st_reg.valid;

  // Frozen low byte does not change while high holds the lock
  chk_lo_frozen: assert property (@(posedge clk) disable iff (rst)
    st_reg.lock == TRS_LOCK_HI_HELD && !hit(host_read, TRS_PTR_REMOTE_LO)
    |=> $stable(lo_q))
    else $error("low byte changed while locked");

  // Frozen high byte while low holds the lock
  chk_hi_frozen: assert property (@(posedge clk) disable iff (rst)
    st_reg.lock == TRS_LOCK_LO_HELD |=> $stable(hi_q))
    else $error("high byte changed while locked");

  // Unlocked pair takes both halves of a conversion
  chk_load_free: assert property (@(posedge clk) disable iff (rst)
    conv_done && st_reg.lock == TRS_LOCK_NONE
    |=> hi_q == $past(conv_result[11:4]) && lo_q == $past(conv_result[3:0]))
    else $error("result not loaded");

  // Any other pointer ends the pair guarantee
  chk_other_drop: assert property (@(posedge clk) disable iff (rst)
    host_read.rd && host_read.ptr != TRS_PTR_REMOTE_HI &&
    host_read.ptr != TRS_PTR_REMOTE_LO |=> st_reg.lock == TRS_LOCK_NONE)
    else $error("lock kept over another read");

  // High byte answer is the stored integer part
  chk_hi_data: assert property (@(posedge clk) disable iff (rst)
    hit(host_read, TRS_PTR_REMOTE_HI)
    |=> read_valid && read_data == $past(hi_q))
    else $error("high byte read wrong");

  // Lower nibble of the low byte reads zero
  chk_lo_data: assert property (@(posedge clk) disable iff (rst)
    hit(host_read, TRS_PTR_REMOTE_LO) |=> read_data[3:0] == 4'h0)
    else $error("low nibble not zero");

  // Busy is sampled in the read cycle
  chk_busy_bit: assert property (@(posedge clk) disable iff (rst)
    hit(host_read, TRS_PTR_FLAGS) |=> read_data[7] == $past(conv_busy))
    else $error("busy bit wrong");

  // Local over cause shows one cycle later
  chk_flag_set: assert property (@(posedge clk) disable iff (rst)
    cond_in.cond[TRS_BIT_LOCAL_OVER] |=> st_reg.flags[TRS_BIT_LOCAL_OVER])
    else $error("local over flag not set");

  // A cause still present survives the read
  chk_flag_keep: assert property (@(posedge clk) disable iff (rst)
    hit(host_read, TRS_PTR_FLAGS) && cond_in.cond[TRS_BIT_OPEN]
    |=> st_reg.flags[TRS_BIT_OPEN])
    else $error("open flag cleared with cause present");

  // With every cause gone a read empties the flags
  chk_flag_clear: assert property (@(posedge clk) disable iff (rst)
    hit(host_read, TRS_PTR_FLAGS) && cond_in.cond == 7'h00
    |=> st_reg.flags == 7'h00)
    else $error("flags not cleared on read");

  // Alert mode holds a limit flag until read
  chk_flag_latch: assert property (@(posedge clk) disable iff (rst)
    !shutdown2_mode && st_reg.flags[TRS_BIT_REMOTE_UNDER] &&
    !host_read.rd |=> st_reg.flags[TRS_BIT_REMOTE_UNDER])
    else $error("latched flag dropped");

  // Host sees the flags as they stood before the clear
  chk_snap_first: assert property (@(posedge clk) disable iff (rst)
    hit(host_read, TRS_PTR_FLAGS)
    |=> read_data[6:0] == $past(st_reg.flags))
    else $error("status not captured before clear");

  // Status read always answers the cycle after
  chk_flags_valid: assert property (@(posedge clk) disable iff (rst)
    hit(host_read, TRS_PTR_FLAGS) |=> read_valid)
    else $error("status read not answered");

  // No strobe, no answer pulse
  chk_valid_quiet: assert property (@(posedge clk) disable iff (rst)
    !host_read.rd |=> !read_valid)
    else $error("answer without a read");

  // Local under cause shows one cycle later
  chk_under_local: assert property (@(posedge clk) disable iff (rst)
    cond_in.cond[TRS_BIT_LOCAL_UNDER] |=> st_reg.flags[TRS_BIT_LOCAL_UNDER])
    else $error("local under flag not set");

  // Remote over cause shows one cycle later
  chk_over_remote: assert property (@(posedge clk) disable iff (rst)
    cond_in.cond[TRS_BIT_REMOTE_OVER] |=> st_reg.flags[TRS_BIT_REMOTE_OVER])
    else $error("remote over flag not set");

  // Remote under cause shows one cycle later
  chk_under_remote: assert property (@(posedge clk) disable iff (rst)
    cond_in.cond[TRS_BIT_REMOTE_UNDER] |=> st_reg.flags[TRS_BIT_REMOTE_UNDER])
    else $error("remote under flag not set");

  // Open junction shows one cycle later
  chk_open_set: assert property (@(posedge clk) disable iff (rst)
    cond_in.cond[TRS_BIT_OPEN] |=> st_reg.flags[TRS_BIT_OPEN])
    else $error("open flag not set");

  // Remote shutdown trip shows one cycle later
  chk_rshut_set: assert property (@(posedge clk) disable iff (rst)
    cond_in.cond[TRS_BIT_RSHUT] |=> st_reg.flags[TRS_BIT_RSHUT])
    else $error("remote shutdown flag not set");

  // Local shutdown trip shows one cycle later
  chk_lshut_set: assert property (@(posedge clk) disable iff (rst)
    cond_in.cond[TRS_BIT_LSHUT] |=> st_reg.flags[TRS_BIT_LSHUT])
    else $error("local shutdown flag not set");

  // Shutdown flags drop as soon as their trips are gone
  chk_shut_follow: assert property (@(posedge clk) disable iff (rst)
    !cond_in.cond[TRS_BIT_RSHUT] && !cond_in.cond[TRS_BIT_LSHUT]
    |=> !st_reg.flags[TRS_BIT_RSHUT] && !st_reg.flags[TRS_BIT_LSHUT])
    else $error("shutdown flag held without its cause");

  // In shutdown2 mode a limit flag follows its cause
  chk_pin2_follow: assert property (@(posedge clk) disable iff (rst)
    shutdown2_mode && !cond_in.cond[TRS_BIT_LOCAL_OVER]
    |=> !st_reg.flags[TRS_BIT_LOCAL_OVER])
    else $error("limit flag latched in shutdown2 mode");

  // Open flag holds in both modes until a status read
  chk_open_latch: assert property (@(posedge clk) disable iff (rst)
    st_reg.flags[TRS_BIT_OPEN] && !hit(host_read, TRS_PTR_FLAGS)
    |=> st_reg.flags[TRS_BIT_OPEN])
    else $error("open flag dropped without a read");

  // High byte read first takes the lock
  chk_lock_hi_take: assert property (@(posedge clk) disable iff (rst)
    hit(host_read, TRS_PTR_REMOTE_HI) && st_reg.lock != TRS_LOCK_LO_HELD
    |=> st_reg.lock == TRS_LOCK_HI_HELD)
    else $error("high read did not lock low byte");

  // Low byte read first takes the lock
  chk_lock_lo_take: assert property (@(posedge clk) disable iff (rst)
    hit(host_read, TRS_PTR_REMOTE_LO) && st_reg.lock != TRS_LOCK_HI_HELD
    |=> st_reg.lock == TRS_LOCK_LO_HELD)
    else $error("low read did not lock high byte");

  // Low byte read while high holds the lock ends the pair lock
  chk_pair_release: assert property (@(posedge clk) disable iff (rst)
    hit(host_read, TRS_PTR_REMOTE_LO) && st_reg.lock == TRS_LOCK_HI_HELD
    |=> st_reg.lock == TRS_LOCK_NONE)
    else $error("lock kept after partner read");

  // Upper nibble of the low byte is the stored fraction
  chk_frac_data: assert property (@(posedge clk) disable iff (rst)
    hit(host_read, TRS_PTR_REMOTE_LO) |=> read_data[7:4] == $past(lo_q))
    else $error("fraction nibble read wrong");

  // Pointers outside this block answer zero
  chk_other_zero: assert property (@(posedge clk) disable iff (rst)
    host_read.rd && host_read.ptr != TRS_PTR_REMOTE_HI &&
    host_read.ptr != TRS_PTR_REMOTE_LO && host_read.ptr != TRS_PTR_FLAGS
    |=> read_data == 8'h00)
    else $error("foreign pointer answered non-zero");

  // Low byte loads whenever high does not hold it
  chk_lo_free: assert property (@(posedge clk) disable iff (rst)
    conv_done && st_reg.lock != TRS_LOCK_HI_HELD
    |=> lo_q == $past(conv_result[3:0]))
    else $error("low byte not loaded");

  // High byte loads whenever low does not hold it
  chk_hi_free: assert property (@(posedge clk) disable iff (rst)
    conv_done && st_reg.lock != TRS_LOCK_LO_HELD
    |=> hi_q == $past(conv_result[11:4]))
    else $error("high byte not loaded");

endmodule
`default_nettype wire

// *** verif/trs_host_model.sv ***
// Host-side reader model issuing register reads
`timescale 1ns/100ps
`default_nettype none
module trs_host_model
  import trs_pkg::*;
(
  input  wire logic       clk,
  output var  trs_read_t  host_read,
  input  wire logic [7:0] read_data,
  input  wire logic       read_valid
);
  initial host_read = '0;

  // One strobe per read; callers pair high and low, in either order, in the next read
  task automatic rd(input logic [7:0] ptr, output logic [7:0] data,
                    output logic ok);
  begin
    @(negedge clk);
    host_read = '{rd: 1'b1, ptr: ptr};
    @(negedge clk);
    host_read.rd = 1'b0;
    // Answer is sampled half a cycle after the taking edge
    data = read_data;
    ok = read_valid;
  end
  endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the result pair and status flags
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import trs_pkg::*;
  logic        clk;
  logic        rst;
  logic        conv_busy;
  logic        conv_done;
  logic        shutdown2_mode;
  logic [11:0] conv_result;
  trs_cond_t   cond_in;
  trs_read_t   host_read;
  logic [7:0]  read_data;
  logic        read_valid;
  int          err_total;
  int          n_checks;

  trs_regs u_dut (.clk(clk), .rst(rst), .conv_busy(conv_busy),
    .conv_done(conv_done), .conv_result(conv_result), .cond_in(cond_in),
    .shutdown2_mode(shutdown2_mode), .host_read(host_read),
    .read_data(read_data), .read_valid(read_valid));

  trs_host_model u_host (.clk(clk), .host_read(host_read),
    .read_data(read_data), .read_valid(read_valid));

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // Finished conversion, one-cycle pulse
  task automatic conv(input logic [11:0] v);
  begin
    @(negedge clk);
    conv_done = 1'b1;
    conv_result = v;
    @(negedge clk);
    conv_done = 1'b0;
  end
  endtask

  // Read one register and compare the byte
  task automatic expect_rd(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
  begin
    u_host.rd(ptr, d, ok);
    n_checks++;
    if (ok !== 1'b1 || d !== exp)
    begin
      err_total++;
      $display("[ERR] %0t ptr %h got %h exp %h", $time, ptr, d, exp);
    end
  end
  endtask

  task automatic conclude;
  begin
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask

  // Watchdog; the sequence needs well under 1000 cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end

  initial
  begin
    rst = 1'b1;
    conv_busy = 1'b0;
    conv_done = 1'b0;
    conv_result = 12'h000;
    cond_in = '0;
    shutdown2_mode = 1'b0;
    err_total = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    expect_rd(TRS_PTR_REMOTE_HI, TRS_RESULT_RST);
    expect_rd(TRS_PTR_FLAGS, TRS_FLAGS_RST);
    expect_rd(8'h03, 8'h00);
    conv(12'h1a5);
    expect_rd(TRS_PTR_REMOTE_HI, 8'h1a);
    expect_rd(TRS_PTR_REMOTE_LO, 8'h50);
    // High first freezes the low byte over a new conversion
    expect_rd(TRS_PTR_REMOTE_HI, 8'h1a);
    conv(12'h2b7);
    expect_rd(TRS_PTR_REMOTE_LO, 8'h50);
    // Low first freezes the high byte; low itself still updates
    conv(12'h3c9);
    expect_rd(TRS_PTR_REMOTE_LO, 8'h90);
    conv(12'h4da);
    expect_rd(TRS_PTR_REMOTE_HI, 8'h3c);
    expect_rd(TRS_PTR_REMOTE_LO, 8'ha0);
    // Another register read in between drops the lock
    expect_rd(TRS_PTR_FLAGS, 8'h00);
    conv(12'h5eb);
    expect_rd(TRS_PTR_REMOTE_HI, 8'h5e);
    // Each cause pulsed alone latches its own bit until read;
    // the two shutdown flags follow their cause and are gone already
    for (int i = 0; i < 7; i++)
    begin
      @(negedge clk);
      cond_in.cond = 7'(1 << i);
      @(negedge clk);
      cond_in.cond = '0;
      expect_rd(TRS_PTR_FLAGS, 8'(TRS_LATCH_ALERT & 7'(1 << i)));
      expect_rd(TRS_PTR_FLAGS, 8'h00);
    end
    // Persisting causes survive the read
    @(negedge clk);
    cond_in.cond = 7'h7f;
    expect_rd(TRS_PTR_FLAGS, 8'h7f);
    expect_rd(TRS_PTR_FLAGS, 8'h7f);
    @(negedge clk);
    cond_in.cond = '0;
    expect_rd(TRS_PTR_FLAGS, 8'h7c);
    expect_rd(TRS_PTR_FLAGS, 8'h00);
    @(negedge clk);
    conv_busy = 1'b1;
    expect_rd(TRS_PTR_FLAGS, 8'h80);
    @(negedge clk);
    conv_busy = 1'b0;
    expect_rd(TRS_PTR_FLAGS, 8'h00);
    // Second pin mode: only the open flag latches
    @(negedge clk);
    shutdown2_mode = 1'b1;
    cond_in.cond = 7'h7f;
    @(negedge clk);
    cond_in.cond = '0;
    expect_rd(TRS_PTR_FLAGS, 8'h04);
    shutdown2_mode = 1'b0;
    conclude();
  end
endmodule
`default_nettype wire
